// [core/dpsf_pkg.sv]
// Package: types and constants for the semaphore port controller
package dpsf_pkg;
  localparam int          DPSF_DW        = 9;
  localparam int          DPSF_AW        = 3;
  localparam int          DPSF_NFLAGS    = 8;
  localparam int          DPSF_CLK_NS    = 50;
  localparam int          DPSF_SETUP_NS  = 100;
  localparam int          DPSF_STROBE_NS = 100;
  localparam int          DPSF_GAP_NS    = 100;
  localparam logic [3:0]  DPSF_SETUP_CYC =
    4'((DPSF_SETUP_NS + DPSF_CLK_NS - 1) / DPSF_CLK_NS);
  localparam logic [3:0]  DPSF_STROBE_CYC =
    4'((DPSF_STROBE_NS + DPSF_CLK_NS - 1) / DPSF_CLK_NS);
  localparam logic [3:0]  DPSF_GAP_CYC =
    4'((DPSF_GAP_NS + DPSF_CLK_NS - 1) / DPSF_CLK_NS);
  localparam logic [3:0]  DPSF_CNT_RST   = 4'h0;
  localparam logic [2:0]  DPSF_IDX_RST   = 3'h0;
  localparam logic [2:0]  DPSF_IDX_LAST  = 3'h7;
  localparam int          DPSF_REQ_BIT   = 0;

  typedef enum logic [2:0] {
    DPSF_IDLE  = 3'h0,
    DPSF_SETUP = 3'h1,
    DPSF_PULSE = 3'h3,
    DPSF_GAP   = 3'h2,
    DPSF_DONE  = 3'h6
  } dpsf_state_t;

  typedef enum logic [1:0] {
    DPSF_OP_READ    = 2'h0,
    DPSF_OP_ACQUIRE = 2'h1,
    DPSF_OP_RELEASE = 2'h2,
    DPSF_OP_INIT    = 2'h3
  } dpsf_op_t;

  // Pins toward one port of the device
  typedef struct packed {
    logic               flag_space_select_n;
    logic               write_n;
    logic               read_enable_n;
    logic [DPSF_AW-1:0] addr;
    logic [DPSF_DW-1:0] dq_o;
    logic               dq_oe_n;
  } dpsf_pins_t;

  typedef struct packed {
    logic     valid;
    dpsf_op_t op;
    logic [DPSF_AW-1:0] flag;
  } dpsf_cmd_t;

  typedef struct packed {
    logic     done;
    logic     granted;
    logic     flag_value;
  } dpsf_rsp_t;
endpackage : dpsf_pkg

// [core/dpsf_sync.sv]
// Two flip-flop synchroniser for the data pins
`timescale 1ns/1ns
module dpsf_sync
  import dpsf_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk_sys_in,
  input  wire logic         nrst_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : dpsf_sync

// [core/dpsf_host.sv]
// Host controller driving one port of the semaphore flags
`timescale 1ns/1ns
// What this block does
// - Poller drops select or output enable between reads.
// - Acquire is write zero then read back, never read first.
// - After failure keep reading or write one to withdraw.
// - Software writes one to every flag from both ports at start; the init op here sweeps this port's eight flags only.
// - Select low marks flag access; three low address bits pick flag.
// - Flags active low: zero requests, one releases.
module dpsf_host
  import dpsf_pkg::*;
(
  input  wire logic               clk_sys_in,
  input  wire logic               nrst_in,
  input  wire dpsf_cmd_t          cmd_in,
  input  wire logic [DPSF_DW-1:0] dq_in,
  output dpsf_pins_t              pins_out,
  output dpsf_rsp_t               rsp_out,
  output logic                    busy_out
);
  typedef struct packed {
    dpsf_state_t        st;
    dpsf_op_t           op;
    logic [DPSF_AW-1:0] flag;
    logic               is_read;
    logic [3:0]         cnt;
    dpsf_pins_t         pins;
    dpsf_rsp_t          rsp;
    logic               busy;
  } dpsf_host_t;

  dpsf_host_t s_q;
  dpsf_host_t s_d;
  logic [DPSF_DW-1:0] dq_sync;

  dpsf_sync #(.W(DPSF_DW)) u_sync (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .async_in   (dq_in),
    .sync_out   (dq_sync)
  );

  function automatic dpsf_pins_t idle_pins();
    dpsf_pins_t p;
    p = '{flag_space_select_n: 1'b1, write_n: 1'b1, read_enable_n: 1'b1,
          addr: '0, dq_o: '1, dq_oe_n: 1'b1};
    return p;
  endfunction : idle_pins

  always_comb begin
    s_d          = s_q;
    s_d.rsp.done = 1'b0;
    case (s_q.st)
      DPSF_IDLE: begin
        s_d.pins = idle_pins();
        if (cmd_in.valid) begin
          s_d.op        = cmd_in.op;
          s_d.flag      = (cmd_in.op == DPSF_OP_INIT) ? DPSF_IDX_RST
                                                      : cmd_in.flag;
          // Acquire writes first, reads back afterward
          s_d.is_read   = (cmd_in.op == DPSF_OP_READ);
          s_d.busy      = 1'b1;
          s_d.cnt       = DPSF_CNT_RST;
          s_d.st        = DPSF_SETUP;
        end
      end
      DPSF_SETUP: begin
        s_d.pins.flag_space_select_n = 1'b0;
        s_d.pins.addr                = s_q.flag;
        // Zero requests, one releases, driven on all nine data bits
        s_d.pins.dq_o    = (s_q.op == DPSF_OP_ACQUIRE) ? '0 : '1;
        s_d.pins.dq_oe_n = s_q.is_read;
        s_d.cnt          = s_q.cnt + 4'h1;
        if (s_q.cnt + 4'h1 >= DPSF_SETUP_CYC) begin
          s_d.cnt = DPSF_CNT_RST;
          s_d.st  = DPSF_PULSE;
          if (s_q.is_read) s_d.pins.read_enable_n = 1'b0;
          else s_d.pins.write_n = 1'b0;
        end
      end
      DPSF_PULSE: begin
        s_d.cnt = s_q.cnt + 4'h1;
        if (s_q.cnt + 4'h1 >= DPSF_STROBE_CYC) begin
          s_d.cnt = DPSF_CNT_RST;
          // Drop select and enables so the next read refreshes
          s_d.pins = idle_pins();
          s_d.st   = DPSF_GAP;
        end
      end
      DPSF_GAP: begin
        s_d.cnt = s_q.cnt + 4'h1;
        // Synchroniser output here was sampled mid strobe
        if (s_q.is_read && s_q.cnt == DPSF_CNT_RST) begin
          s_d.rsp.flag_value = dq_sync[DPSF_REQ_BIT];
          s_d.rsp.granted    = ~dq_sync[DPSF_REQ_BIT];
        end
        if (s_q.cnt + 4'h1 >= DPSF_GAP_CYC) begin
          s_d.cnt = DPSF_CNT_RST;
          s_d.st  = DPSF_DONE;
          if (s_q.op == DPSF_OP_ACQUIRE && !s_q.is_read) begin
            s_d.is_read = 1'b1;
            s_d.st      = DPSF_SETUP;
          end else if (s_q.op == DPSF_OP_INIT &&
                       s_q.flag != DPSF_IDX_LAST) begin
            s_d.flag = s_q.flag + 3'h1;
            s_d.st   = DPSF_SETUP;
          end
        end
      end
      DPSF_DONE: begin
        if (s_q.op != DPSF_OP_READ && s_q.op != DPSF_OP_ACQUIRE) begin
          s_d.rsp.granted    = 1'b0;
          s_d.rsp.flag_value = 1'b1;
        end
        s_d.rsp.done = 1'b1;
        s_d.busy     = 1'b0;
        s_d.st       = DPSF_IDLE;
      end
      default: begin
        s_d.st   = DPSF_IDLE;
        s_d.pins = idle_pins();
        s_d.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '{st: DPSF_IDLE, op: DPSF_OP_READ, flag: DPSF_IDX_RST,
               is_read: 1'b0, cnt: DPSF_CNT_RST,
               pins: '{flag_space_select_n: 1'b1, write_n: 1'b1,
                       read_enable_n: 1'b1, addr: 3'h0,
                       dq_o: 9'h1FF, dq_oe_n: 1'b1},
               rsp: '{done: 1'b0, granted: 1'b0, flag_value: 1'b1},
               busy: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign pins_out = s_q.pins;
  assign rsp_out  = s_q.rsp;
  assign busy_out = s_q.busy;

  sequence sel_drop_s;
    pins_out.flag_space_select_n || pins_out.read_enable_n;
  endsequence

  property read_gap_p;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      $rose(pins_out.read_enable_n) |-> sel_drop_s [*2];
  endproperty
  read_gap_a: assert property (read_gap_p)
    else $error("read strobe not released between reads");

  acquire_order_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (s_q.st == DPSF_IDLE && cmd_in.valid &&
       cmd_in.op == DPSF_OP_ACQUIRE) |=> (s_q.is_read == 1'b0))
    else $error("acquire began with a read");

  sequence acq_write_s;
    $fell(pins_out.write_n) && s_q.op == DPSF_OP_ACQUIRE;
  endsequence

  acquire_readback_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
      acq_write_s |-> ##[1:8] !pins_out.read_enable_n)
    else $error("acquire write not followed by read back");

  release_one_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (!pins_out.write_n && s_q.op == DPSF_OP_RELEASE)
        |-> pins_out.dq_o[DPSF_REQ_BIT])
    else $error("release wrote a zero");

  strobe_sel_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (!pins_out.write_n || !pins_out.read_enable_n)
        |-> !pins_out.flag_space_select_n)
    else $error("strobe without flag space select");

  addr_hold_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (!pins_out.write_n || !pins_out.read_enable_n) |-> $stable(pins_out.addr))
    else $error("flag address moved during strobe");

  write_drive_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
      !pins_out.write_n |-> !pins_out.dq_oe_n &&
        pins_out.dq_o[DPSF_REQ_BIT] == (s_q.op != DPSF_OP_ACQUIRE))
    else $error("write without correct data drive");

  init_sweep_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (s_q.op == DPSF_OP_INIT && rsp_out.done) |-> s_q.flag == 3'h7)
    else $error("init finished before last flag");

  read_oe_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
      !pins_out.read_enable_n |-> pins_out.dq_oe_n)
    else $error("host drives data during read");

  done_pulse_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
      rsp_out.done |=> !rsp_out.done && !busy_out)
    else $error("done not a single pulse");
endmodule : dpsf_host

// [sim/dpsf_dev_model.sv]
// Behavioural model of the eight semaphore flags, both ports
`timescale 1ns/1ns
module dpsf_dev_model
  import dpsf_pkg::*;
#(
  parameter int DLY_NS = 0
) (
  input  wire dpsf_pins_t        pins_in,
  input  wire logic [2:0]        r_flag_in,
  input  wire logic              r_wr_in,
  input  wire logic              r_dat_in,
  output logic [DPSF_DW-1:0]     dq_out,
  output logic [DPSF_NFLAGS-1:0] r_view_out
);
  logic [7:0]         lreq  = 8'h5A; // Arbitrary power-up latches
  logic [7:0]         rreq  = 8'hC3;
  logic [7:0]         own_l = 8'h00;
  logic [7:0]         own_r = 8'h00;
  logic [DPSF_DW-1:0] held  = '1;
  wire  logic [2:0]   a     = pins_in.addr; // Flag select
  wire  logic         rd_act = !pins_in.flag_space_select_n &&
                               !pins_in.read_enable_n;

  assign r_view_out = ~own_r;
  initial dq_out = 9'h000;

  task automatic resolve(input logic [2:0] i);
    if (own_l[i] && lreq[i]) own_l[i] = 1'b0;
    if (own_r[i] && rreq[i]) own_r[i] = 1'b0;
    if (!own_l[i] && !own_r[i]) begin // First zero owns
      if (!lreq[i]) own_l[i] = 1'b1;
      else if (!rreq[i]) own_r[i] = 1'b1;
    end
  endtask : resolve

  always @(negedge pins_in.write_n) begin
    if (!pins_in.flag_space_select_n) begin
      lreq[a] = pins_in.dq_o[0]; // Bit zero only
      resolve(a);
    end
  end

  always @(posedge r_wr_in) begin
    rreq[r_flag_in] = r_dat_in;
    resolve(r_flag_in);
  end

  always @(rd_act) begin
    if (rd_act) held = {DPSF_DW{~own_l[a]}};
    dq_out <= #(DLY_NS) (rd_act ? held : ~held);
  end
endmodule : dpsf_dev_model

// [sim/tb_dual_port_semaphore_flags.sv]
// Self-checking bench for the semaphore host controller
`timescale 1ns/1ns
module tb_dual_port_semaphore_flags
  import dpsf_pkg::*;
;
  logic               clk_sys_in;
  logic               nrst_in;
  dpsf_cmd_t          cmd;
  logic [DPSF_DW-1:0] dq;
  dpsf_pins_t         pins;
  dpsf_rsp_t          rsp;
  logic               busy;
  logic [2:0]         r_flag;
  logic               r_wr;
  logic               r_dat;
  logic [7:0]         r_view;
  int                 fail_count = 0;
  int                 num_checks = 0;
  int                 cyc = 0;

  dpsf_host u_dpsf_host (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .cmd_in(cmd), .dq_in(dq), .pins_out(pins), .rsp_out(rsp),
    .busy_out(busy));
  dpsf_dev_model u_dpsf_dev_model (.pins_in(pins), .r_flag_in(r_flag),
    .r_wr_in(r_wr), .r_dat_in(r_dat), .dq_out(dq), .r_view_out(r_view));

  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic chk(input logic [7:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk

  task automatic run_cmd(input dpsf_op_t op, input logic [2:0] f,
                         input logic [7:0] lat);
    int n;
    @(negedge clk_sys_in);
    cmd = '{valid: 1'b1, op: op, flag: f};
    @(negedge clk_sys_in);
    cmd.valid = 1'b0;
    chk({7'h00, busy}, 8'h01, "busy after accept");
    n = 0;
    while (rsp.done !== 1'b1 && n < 100) begin
      @(negedge clk_sys_in);
      n++;
    end
    chk(8'(n), lat, "latency");
    chk({7'h00, busy}, 8'h00, "idle at done");
  endtask : run_cmd

  task automatic rw(input logic [2:0] f, input logic d);
    @(negedge clk_sys_in);
    r_flag = f;
    r_dat = d;
    r_wr = 1'b1;
    @(negedge clk_sys_in);
    r_wr = 1'b0;
  endtask : rw

  task automatic rd_left(input logic [2:0] f, input logic g);
    run_cmd(DPSF_OP_READ, f, 8'h07);
    chk({7'h00, rsp.granted}, {7'h00, g}, "granted");
    chk({7'h00, rsp.flag_value}, {7'h00, ~g}, "value");
  endtask : rd_left

  task automatic t_init;
    run_cmd(DPSF_OP_INIT, 3'h0, 8'h31);
    for (int i = 0; i < 8; i++) rw(3'(i), 1'b1);
    for (int i = 0; i < 8; i++) rd_left(3'(i), 1'b0);
    chk(r_view, 8'hFF, "right view free");
  endtask : t_init

  task automatic t_acquire;
    run_cmd(DPSF_OP_ACQUIRE, 3'h3, 8'h0D);
    chk({7'h00, rsp.granted}, 8'h01, "acquire");
    chk(r_view, 8'hFF, "right sees one");
    rd_left(3'h4, 1'b0);
  endtask : t_acquire

  task automatic t_pending;
    rw(3'h3, 1'b0);
    rd_left(3'h3, 1'b1);
    chk(r_view, 8'hFF, "right pending");
    run_cmd(DPSF_OP_RELEASE, 3'h3, 8'h07);
    rd_left(3'h3, 1'b0);
    chk(r_view, 8'hF7, "handover");
  endtask : t_pending

  task automatic t_fail;
    run_cmd(DPSF_OP_ACQUIRE, 3'h3, 8'h0D);
    chk({7'h00, rsp.granted}, 8'h00, "fail grant");
    chk({7'h00, rsp.flag_value}, 8'h01, "fail value");
    run_cmd(DPSF_OP_RELEASE, 3'h3, 8'h07);
    rw(3'h3, 1'b1);
    chk(r_view, 8'hFF, "freed");
    rd_left(3'h3, 1'b0);
  endtask : t_fail

  task automatic t_edges;
    run_cmd(DPSF_OP_ACQUIRE, 3'h7, 8'h0D);
    run_cmd(DPSF_OP_ACQUIRE, 3'h0, 8'h0D);
    rd_left(3'h7, 1'b1);
    rd_left(3'h1, 1'b0);
    rw(3'h7, 1'b0);
    run_cmd(DPSF_OP_RELEASE, 3'h7, 8'h07);
    chk(r_view, 8'h7F, "flag seven moved");
    rd_left(3'h0, 1'b1);
  endtask : t_edges

  initial begin
    nrst_in = 1'b0;
    cmd = '0;
    r_flag = 3'h0;
    r_wr = 1'b0;
    r_dat = 1'b1;
    repeat (5) @(negedge clk_sys_in);
    nrst_in = 1'b1;
    t_init();
    t_acquire();
    t_pending();
    t_fail();
    t_edges();
    stop_test();
  end
endmodule : tb_dual_port_semaphore_flags
